// ==== common/cra_params.svh ====
/*
 * Constants for the coefficient memory block addressing logic.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef CRA_PARAMS_SVH
`define CRA_PARAMS_SVH

// ****************************************
// Address geometry
// ****************************************
`define CRA_ADDR_W 6
`define CRA_BLK_W 3
`define CRA_IDX_W 3
`define CRA_NUM_WORDS 40
`define CRA_NUM_BLOCKS 5
`define CRA_WORDS_PER_BLK 8
`define CRA_DATA_W 16
`define CRA_IDX_FIRST 3'h7
`define CRA_IDX_LAST 3'h0
`define CRA_RESP_SPLIT 3'h4

// ****************************************
// Block numbers
// ****************************************
`define CRA_BLK_IMPEDANCE 3'h0
`define CRA_BLK_ECHO 3'h1
`define CRA_BLK_GAIN_SCALE 3'h2
`define CRA_BLK_TRANSMIT 3'h3
`define CRA_BLK_RECEIVE 3'h4

`endif

// ==== common/cra_pkg.sv ====
/*
 * Types for the coefficient memory block addressing logic.
 * Assumes cra_params.svh is on the include path.
 */
`include "cra_params.svh"

package cra_pkg;

    // ****************************************
    // Command and word access carriers
    // ****************************************
    typedef struct packed {
        logic write;                       // One for write, zero for read
        logic [`CRA_BLK_W-1:0] block;      // Block number only
    } cra_cmd_s;

    typedef struct packed {
        logic [`CRA_BLK_W-1:0] block;      // Upper address bits
        logic [`CRA_IDX_W-1:0] index;      // Lower address bits
    } cra_addr_s;

    // Region that a word belongs to
    typedef enum logic [6:0] {
        CRA_REG_IMPEDANCE = 7'h01,
        CRA_REG_ECHO = 7'h02,
        CRA_REG_GAIN_SCALE = 7'h04,
        CRA_REG_TX_RESP = 7'h08,
        CRA_REG_TX_GAIN = 7'h10,
        CRA_REG_RX_RESP = 7'h20,
        CRA_REG_RX_GAIN = 7'h40
    } cra_region_e;

    // Sequencer states
    typedef enum logic [1:0] {
        CRA_IDLE = 2'h1,
        CRA_RUN = 2'h2
    } cra_state_e;

endpackage

// ==== design/cra_region_decode.sv ====
/*
 * Region decoder: names the coefficient region of one 6-bit word address.
 * Assumes a legal block number; unassigned blocks return the lowest region.
 */
`timescale 1ns/1ns
`include "cra_params.svh"

module cra_region_decode (
    input wire cra_pkg::cra_addr_s i_addr,
    output cra_pkg::cra_region_e o_region
);
    import cra_pkg::*;

    // ****************************************
    // Block and half-block decode
    // ****************************************
    // Pure decode, so the caller registers the result
    always_comb begin
        unique case (i_addr.block)
            `CRA_BLK_IMPEDANCE: o_region = CRA_REG_IMPEDANCE;
            `CRA_BLK_ECHO: o_region = CRA_REG_ECHO;
            `CRA_BLK_GAIN_SCALE: o_region = CRA_REG_GAIN_SCALE;
            `CRA_BLK_TRANSMIT: begin
                // Low half is response, high half is gain
                o_region = (i_addr.index >= `CRA_RESP_SPLIT) ? CRA_REG_TX_GAIN : CRA_REG_TX_RESP;
            end
            `CRA_BLK_RECEIVE: begin
                o_region = (i_addr.index >= `CRA_RESP_SPLIT) ? CRA_REG_RX_GAIN : CRA_REG_RX_RESP;
            end
            // Unassigned block codes fall back to the lowest region
            default: o_region = CRA_REG_IMPEDANCE;
        endcase
    end
endmodule

// ==== design/cra_block_addr.sv ====
/*
 * Coefficient memory of 40 words with block-addressed eight-word bursts.
 * Assumes commands and data come from logic on i_sys_clk; no pin inputs.
 */
`timescale 1ns/1ns
`include "cra_params.svh"

// Behaviour
// - Word address is block over word index
// - Five blocks of eight consecutive words
// - Command carries block number only
// - One command moves all eight words
// - Word index counts down 111 to 000
// - Block numbers map to five coefficient groups
// - Response low half, gain high half
// - Receive gain access includes receive response
module cra_block_addr (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire cra_pkg::cra_cmd_s i_cmd,
    input wire logic [`CRA_DATA_W-1:0] i_wr_data,
    output logic o_word_valid,
    output cra_pkg::cra_addr_s o_word_addr,
    output cra_pkg::cra_region_e o_word_region,
    output logic [`CRA_DATA_W-1:0] o_rd_data,
    output logic o_wr_take,
    output logic o_busy,
    output logic o_cmd_error
);
    import cra_pkg::*;

    // ****************************************
    // Storage and sequencer state
    // ****************************************
    logic [`CRA_DATA_W-1:0] mem [0:`CRA_NUM_WORDS-1]; // Coefficient words
    cra_state_e state;                  // Sequencer state
    cra_state_e next_state;
    logic [`CRA_BLK_W-1:0] blk;         // Latched block number
    logic [`CRA_BLK_W-1:0] next_blk;
    logic [`CRA_IDX_W-1:0] idx;         // Current word index
    logic [`CRA_IDX_W-1:0] next_idx;
    logic wr_mode;                      // Burst direction
    logic next_wr_mode;
    logic err;                          // Sticky bad-block flag
    logic next_err;
    logic word_valid;                   // Word strobe register
    logic next_word_valid;
    cra_addr_s cur_addr;                // Address of word in flight
    cra_region_e cur_region;
    cra_addr_s word_addr;
    cra_region_e word_region;
    logic [`CRA_DATA_W-1:0] rd_data;
    logic [5:0] word_num;               // Linear word number

    // Legal block check, used for accept and assertions
    function automatic logic blk_legal(input logic [`CRA_BLK_W-1:0] b);
        blk_legal = (b <= `CRA_BLK_RECEIVE);
    endfunction

    assign cur_addr.block = blk;
    assign cur_addr.index = idx;
    // Block times eight plus index gives consecutive words
    assign word_num = {blk, idx};

    cra_region_decode u_decode (
        .i_addr(cur_addr),
        .o_region(cur_region)
    );

    // ****************************************
    // Sequencer next state
    // ****************************************
    // Only accepts when idle, so a burst never gets re-aimed midway
    always_comb begin
        next_state = state;
        next_blk = blk;
        next_idx = idx;
        next_wr_mode = wr_mode;
        next_err = err;
        next_word_valid = 1'b0;
        unique case (state)
            CRA_IDLE: begin
                if (i_cmd_valid) begin
                    if (blk_legal(i_cmd.block)) begin
                        // Index is internal; host never supplies it
                        next_blk = i_cmd.block;
                        next_idx = `CRA_IDX_FIRST;
                        next_wr_mode = i_cmd.write;
                        next_state = CRA_RUN;
                    end else begin
                        // Unassigned block is dropped, flag kept
                        next_err = 1'b1;
                    end
                end
            end
            CRA_RUN: begin
                next_word_valid = 1'b1;
                if (idx == `CRA_IDX_LAST) begin
                    next_state = CRA_IDLE;
                end else begin
                    next_idx = idx - 3'h1;
                end
            end
            default: next_state = CRA_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state <= CRA_IDLE;
            blk <= 3'h0;
            idx <= 3'h0;
            wr_mode <= 1'b0;
            err <= 1'b0;
            word_valid <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            blk <= next_blk;
            idx <= next_idx;
            wr_mode <= next_wr_mode;
            err <= next_err;
            word_valid <= next_word_valid;
        end
    end

    // ****************************************
    // Burst length helper for the checks
    // ****************************************
    logic [3:0] run_count;              // Enabled busy cycles so far in this burst
    logic [3:0] next_run_count;

    // Counts only enabled cycles, so a stall does not stretch the burst length
    always_comb begin
        next_run_count = run_count;
        if (state == CRA_IDLE) begin
            // Cleared between bursts
            next_run_count = 4'h0;
        end else if (state == CRA_RUN) begin
            next_run_count = run_count + 4'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            run_count <= 4'h0;
        end else if (i_ce) begin
            run_count <= next_run_count;
        end
    end

    // ****************************************
    // Memory access and word outputs
    // ****************************************
    // Receive block covers both its response and gain halves in one burst
    always_comb begin
        word_addr = cur_addr;
        word_region = cur_region;
        rd_data = mem[word_num];
    end

    // Memory has no reset; contents are undefined until written
    always_ff @(posedge i_sys_clk) begin
        if (i_ce && state == CRA_RUN) begin
            if (wr_mode) begin
                mem[word_num] <= i_wr_data;
            end
        end
    end

    cra_addr_s word_addr_q;
    cra_region_e word_region_q;
    logic [`CRA_DATA_W-1:0] rd_data_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            word_addr_q <= '0;
            word_region_q <= CRA_REG_IMPEDANCE;
            rd_data_q <= '0;
        end else if (i_ce && state == CRA_RUN) begin
            word_addr_q <= word_addr;
            word_region_q <= word_region;
            rd_data_q <= wr_mode ? i_wr_data : rd_data;
        end
    end

    assign o_cmd_ready = (state == CRA_IDLE);
    assign o_wr_take = (state == CRA_RUN) && wr_mode && i_ce;
    assign o_busy = (state == CRA_RUN);
    assign o_word_valid = word_valid;
    assign o_word_addr = word_addr_q;
    assign o_word_region = word_region_q;
    assign o_rd_data = rd_data_q;
    assign o_cmd_error = err;

    // ****************************************
    // Checks
    // ****************************************
    a_burst_eight: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_busy && i_ce && idx == 3'h0) |-> (run_count == 4'h7 ##1 !o_busy))
        else $error("burst is not eight words");
    a_burst_cap: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_busy |-> run_count <= 4'h7)
        else $error("burst ran past eight words");
    a_index_down: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_busy && i_ce && idx != 3'h0) |=> (idx == $past(idx) - 3'h1))
        else $error("word index did not count down");
    a_index_start: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_busy) |-> idx == 3'h7)
        else $error("burst did not start at top word");
    a_block_held: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_busy && $past(o_busy)) |-> $stable(blk))
        else $error("block changed within burst");
    a_block_legal: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_busy |-> blk_legal(blk))
        else $error("burst on unassigned block");
    a_addr_compose: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_busy |-> word_num == blk * 6'h08 + idx && word_num < 6'h28)
        else $error("word address not block over index");
    a_tx_split: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_busy && blk == 3'h3) |-> (cur_region == (idx[2] ? CRA_REG_TX_GAIN : CRA_REG_TX_RESP)))
        else $error("transmit half split wrong");
    a_rx_pair: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_busy && i_ce && blk == 3'h4 && idx == 3'h4) |=> cur_region == CRA_REG_RX_RESP)
        else $error("receive response not reached after receive gain");
    a_region_map: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_busy && blk == 3'h1) |-> cur_region == CRA_REG_ECHO)
        else $error("echo block mapped wrong");
    a_words_group: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_busy && i_ce && idx != 3'h0) |=> word_num == $past(word_num) - 6'h01)
        else $error("burst words not consecutive");
    a_rx_gain_first: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_busy && blk == 3'h4 && idx[2]) |-> cur_region == CRA_REG_RX_GAIN)
        else $error("receive gain half mapped wrong");
endmodule

// ==== verification/test_cra_block_addr.sv ====
/*
 * Self-checking bench for the coefficient memory block addressing logic.
 * Assumes cra_pkg is compiled first and cra_params.svh is on the include path.
 */
`timescale 1ns/1ns
`include "cra_params.svh"

module test_cra_block_addr;
    import cra_pkg::*;

    // ****************************************
    // Stimulus and observation signals
    // ****************************************
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_ce = 1'b1;
    logic i_cmd_valid = 1'b0;
    cra_cmd_s i_cmd = '0;
    logic [`CRA_DATA_W-1:0] i_wr_data = '0;
    logic o_cmd_ready, o_word_valid, o_wr_take, o_busy, o_cmd_error;
    cra_addr_s o_word_addr;
    cra_region_e o_word_region;
    logic [`CRA_DATA_W-1:0] o_rd_data;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic exp_err = 1'b0; // Sticky error the bench expects

    cra_block_addr dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce), .i_cmd_valid(i_cmd_valid),
        .o_cmd_ready(o_cmd_ready), .i_cmd(i_cmd), .i_wr_data(i_wr_data), .o_word_valid(o_word_valid),
        .o_word_addr(o_word_addr), .o_word_region(o_word_region), .o_rd_data(o_rd_data),
        .o_wr_take(o_wr_take), .o_busy(o_busy), .o_cmd_error(o_cmd_error));

    // 100 MHz clock
    always #5 i_sys_clk = ~i_sys_clk;

    // ****************************************
    // Helpers
    // ****************************************
    // Compare one value, four-state exact
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Word pattern unique per address, so a wrong index shows in the data
    function automatic logic [15:0] pat(input logic [2:0] b, input logic [2:0] x);
        return {b, x, 4'h5, b, x};
    endfunction

    // Region of a word, worked out from block and index
    function automatic logic [6:0] exp_region(input logic [2:0] b, input logic [2:0] x);
        case (b)
            3'h0: return 7'h01;
            3'h1: return 7'h02;
            3'h2: return 7'h04;
            3'h3: return x[2] ? 7'h10 : 7'h08;
            default: return x[2] ? 7'h40 : 7'h20;
        endcase
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    // One burst; entered just after a falling edge, left at one, so calls chain back to back
    task automatic burst(input logic wr, input logic [2:0] b, input logic stall);
        logic [2:0] x;
        i_cmd_valid = 1'b1;
        i_cmd = {wr, b};
        @(posedge i_sys_clk);
        for (int k = 1; k <= 9; k++) begin
            @(negedge i_sys_clk);
            i_cmd_valid = 1'b0;
            x = 3'(9 - k);
            chk(o_busy, k <= 8);
            chk(o_cmd_ready, k == 9);
            chk(o_wr_take, wr && k <= 8);
            if (k <= 8) begin
                i_wr_data = pat(b, 3'(8 - k));
            end
            chk(o_word_valid, k >= 2);
            if (k >= 2) begin
                chk(o_word_addr, {b, x});
                chk(o_word_region, exp_region(b, x));
                chk(o_rd_data, pat(b, x));
            end
            chk(o_cmd_error, exp_err);
            // Freeze mid-burst: nothing may advance while enable is low
            if (stall && k == 3) begin
                i_ce = 1'b0;
                repeat (3) begin
                    @(negedge i_sys_clk);
                    chk(o_busy, 1'b1);
                    chk(o_wr_take, 1'b0);
                    chk(o_word_addr, {b, 3'h6});
                end
                i_ce = 1'b1;
            end
        end
    endtask

    // Unassigned block codes are dropped and flagged
    task automatic bad_block(input logic [2:0] b);
        i_cmd_valid = 1'b1;
        i_cmd = {1'b1, b};
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_cmd_valid = 1'b0;
        exp_err = 1'b1;
        repeat (3) begin
            chk(o_busy, 1'b0);
            chk(o_word_valid, 1'b0);
            chk(o_cmd_error, 1'b1);
            @(negedge i_sys_clk);
        end
    endtask

    // Reset values at the ports
    task automatic reset_values;
        chk(o_cmd_ready, 1'b1);
        chk(o_busy, 1'b0);
        chk(o_word_valid, 1'b0);
        chk(o_word_addr, 6'h00);
        chk(o_word_region, 7'h01);
        chk(o_rd_data, 16'h0000);
        chk(o_cmd_error, 1'b0);
    endtask

    // ****************************************
    // Verdict and hang guard
    // ****************************************
    task automatic end_sim;
        $display("Checks: %0d, mismatches: %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Run needs about 130 cycles; the ceiling leaves a wide margin
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_sim();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_srst = 1'b0;
        reset_values();
        for (int b = 0; b < 5; b++) begin
            burst(1'b1, 3'(b), 1'b0);
        end
        for (int b = 5; b < 8; b++) begin
            bad_block(3'(b));
        end
        burst(1'b0, 3'h4, 1'b1);
        for (int b = 0; b < 4; b++) begin
            burst(1'b0, 3'(b), 1'b0);
        end
        // Second reset mid-run clears the flag but keeps the memory
        i_srst = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        i_srst = 1'b0;
        exp_err = 1'b0;
        reset_values();
        burst(1'b0, 3'h3, 1'b0);
        end_sim();
    end
endmodule
